// File: ifd_pkg.sv
/*
  Shared constants, enumerations and carriers for the instruction field
  decoder core and its register slave.
  Assumes a single 50 MHz clock domain and an AHB-Lite master with 32-bit data.
*/
package ifd_pkg;

  // bus byte offsets
  localparam logic [7:0] ADDR_INSTR = 8'h00;
  localparam logic [7:0] ADDR_WREG  = 8'h04;
  localparam logic [7:0] ADDR_STAT  = 8'h08;
  localparam logic [7:0] ADDR_PC    = 8'h0C;
  localparam logic [7:0] ADDR_FADDR = 8'h10;
  localparam logic [7:0] ADDR_FDATA = 8'h14;
  localparam logic [7:0] ADDR_CYC   = 8'h18;

  // data-register addresses with special handling
  localparam logic [6:0] FILE_PC_LOW = 7'h02;
  localparam logic [6:0] FILE_STATUS = 7'h03;
  localparam logic [6:0] FILE_LATCH  = 7'h0A;

  // status bit positions
  localparam int ST_C  = 0;
  localparam int ST_NC = 1;
  localparam int ST_Z  = 2;

  // oscillator periods per instruction cycle
  localparam int         Q_PER_CYCLE = 4;
  localparam logic [1:0] Q_LAST      = 2'(Q_PER_CYCLE - 1);

  // reset values
  localparam logic [7:0]  W_RST      = 8'h00;
  localparam logic [7:0]  STATUS_RST = 8'h00;
  localparam logic [12:0] PC_RST     = 13'h0000;
  localparam logic [4:0]  LATCH_RST  = 5'h00;
  localparam logic [13:0] INSTR_RST  = 14'h0000;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

  typedef enum logic [1:0] {IFD_BYTE, IFD_BIT, IFD_LITCTL} ifd_class_t;

  typedef enum logic [1:0] {PH_IDLE, PH_EXEC, PH_NOP} ifd_phase_t;

  typedef struct packed {
    ifd_class_t  cls;
    logic [7:0]  result;
    logic        wr_file;
    logic        wr_w;
    logic [6:0]  faddr;
    logic [2:0]  fmask;
    logic [2:0]  fval;
    logic        skip;
    logic        jump;
    logic        ret;
    logic [10:0] k11;
  } ifd_dec_t;

  typedef struct packed {
    ifd_phase_t  phase;
    logic [1:0]  q;
    logic [13:0] instr;
    logic [7:0]  w;
    logic [7:0]  status;
    logic [12:0] pc;
    logic [4:0]  latch;
    logic [6:0]  faddr;
    logic [31:0] cycles;
    logic        dp_valid;
    logic        dp_write;
    logic [7:0]  dp_addr;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } ifd_state_t;

endpackage

// File: ifd_field_decode.sv
/*
  Combinational operand-field decoder and ALU for 14-bit instruction words.
  Assumes operands (accumulator, addressed register, carry) are presented
  by the core and the result is committed there.
*/
`timescale 1ns/1ps
module ifd_field_decode (
  input  wire logic [13:0]     instr,
  input  wire logic [7:0]      wreg,
  input  wire logic [7:0]      fdata,
  input  wire logic            carry_in,
  output ifd_pkg::ifd_dec_t    dec
);

  // returns {nibble carry, carry, sum}
  function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b, input logic cin);
    logic [4:0] lo;
    logic [8:0] full;
    lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    add8 = {lo[4], full[8], full[7:0]};
  endfunction

  logic [9:0] sum;
  logic [7:0] bmask;
  logic       c;
  logic       nc;

  always_comb
  begin
    dec   = '0;
    sum   = '0;
    c     = carry_in;
    nc    = 1'b0;
    bmask = 8'h01 << instr[9:7];
    dec.faddr = instr[6:0];
    dec.k11   = instr[10:0];
    case (instr[13:12])
      2'b00:
      begin
        dec.cls     = ifd_pkg::IFD_BYTE;
        dec.wr_file = instr[7];
        dec.wr_w    = !instr[7];
        dec.fmask   = 3'h4;
        case (instr[11:8])
          4'h0:
          begin
            dec.result = wreg;
            dec.fmask  = 3'h0;
            dec.wr_w   = 1'b0;
            dec.ret    = !instr[7] && instr[6:1] == 6'h04;
          end
          4'h1: dec.result = 8'h00;
          4'h2:
          begin
            sum        = add8(fdata, ~wreg, 1'b1);
            dec.result = sum[7:0];
            c          = sum[8];
            nc         = sum[9];
            dec.fmask  = 3'h7;
          end
          4'h3: dec.result = fdata - 8'h01;
          4'h4: dec.result = fdata | wreg;
          4'h5: dec.result = fdata & wreg;
          4'h6: dec.result = fdata ^ wreg;
          4'h7:
          begin
            sum        = add8(fdata, wreg, 1'b0);
            dec.result = sum[7:0];
            c          = sum[8];
            nc         = sum[9];
            dec.fmask  = 3'h7;
          end
          4'h8: dec.result = fdata;
          4'h9: dec.result = ~fdata;
          4'hA: dec.result = fdata + 8'h01;
          4'hB:
          begin
            dec.result = fdata - 8'h01;
            dec.fmask  = 3'h0;
            dec.skip   = dec.result == 8'h00;
          end
          4'hC:
          begin
            dec.result = {carry_in, fdata[7:1]};
            c          = fdata[0];
            dec.fmask  = 3'h1;
          end
          4'hD:
          begin
            dec.result = {fdata[6:0], carry_in};
            c          = fdata[7];
            dec.fmask  = 3'h1;
          end
          4'hE:
          begin
            dec.result = {fdata[3:0], fdata[7:4]};
            dec.fmask  = 3'h0;
          end
          default:
          begin
            dec.result = fdata + 8'h01;
            dec.fmask  = 3'h0;
            dec.skip   = dec.result == 8'h00;
          end
        endcase
      end
      2'b01:
      begin
        dec.cls = ifd_pkg::IFD_BIT;
        case (instr[11:10])
          2'b00: dec.result = fdata & ~bmask;
          2'b01: dec.result = fdata | bmask;
          2'b10: dec.skip = (fdata & bmask) == 8'h00;
          default: dec.skip = (fdata & bmask) != 8'h00;
        endcase
        dec.wr_file = !instr[11];
      end
      2'b10:
      begin
        dec.cls  = ifd_pkg::IFD_LITCTL;
        dec.jump = 1'b1;
      end
      default:
      begin
        dec.cls  = ifd_pkg::IFD_LITCTL;
        dec.wr_w = 1'b1;
        dec.fmask = 3'h4;
        casez (instr[11:8])
          4'b00??:
          begin
            dec.result = instr[7:0];
            dec.fmask  = 3'h0;
          end
          4'b01??:
          begin
            dec.result = instr[7:0];
            dec.fmask  = 3'h0;
            dec.ret    = 1'b1;
          end
          4'b1000: dec.result = wreg | instr[7:0];
          4'b1001: dec.result = wreg & instr[7:0];
          4'b1010: dec.result = wreg ^ instr[7:0];
          4'b110?, 4'b111?:
          begin
            sum        = instr[9] ? add8(instr[7:0], wreg, 1'b0) : add8(instr[7:0], ~wreg, 1'b1);
            dec.result = sum[7:0];
            c          = sum[8];
            nc         = sum[9];
            dec.fmask  = 3'h7;
          end
          default:
          begin
            dec.wr_w  = 1'b0;
            dec.fmask = 3'h0;
          end
        endcase
      end
    endcase
    dec.fval[ifd_pkg::ST_Z]  = dec.result == 8'h00;
    dec.fval[ifd_pkg::ST_NC] = nc;
    dec.fval[ifd_pkg::ST_C]  = c;
  end

endmodule

// File: ifd_core_top.sv
/*
  Instruction field decoder core with an AHB-Lite register slave: software
  loads a 14-bit instruction, the core runs it over four clocks per cycle
  against a 128-byte data file with accumulator, status, counter and latch.
  Assumes the slave is the only one on the bus, so hready equals hreadyout.
*/
// Our own choices: register access over AHB-Lite and the register offsets.
// Behaviour
// - file-address field selects one of 128 data registers, 0x00 to 0x7F
// - bit-select field names one bit of the addressed 8-bit register
// - destination bit 0 writes accumulator, 1 writes addressed register
// - don't-care opcode bits do not change decoding
// - one cycle per instruction; taken skip or counter change adds a no-op cycle
// - each instruction cycle lasts exactly four clock periods
// - every data register, special ones too, is source and destination
// - arithmetic flags override written zero, carry and nibble-carry bits of status
// - clearing status zeroes it, then sets zero flag
// - reading counter low byte yields current value without changing counter
// - writing counter low byte also loads high byte from holding latch
// - read-modify-write on low byte uses old value, then loads both bytes
// - instructions sort into byte, bit and literal-control classes
// - each instruction is one 14-bit word of opcode and operand fields
// - bit set and clear rewrite the whole register, one bit changed
`timescale 1ns/1ps
module ifd_core_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp
);

  localparam int FILE_DEPTH = 128;

  ifd_pkg::ifd_state_t s_reg;
  ifd_pkg::ifd_state_t s_next;
  ifd_pkg::ifd_dec_t   dec;

  logic [7:0] file_mem [0:FILE_DEPTH-1];
  logic       mem_we;
  logic [6:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [7:0] core_fdata;
  logic [7:0] bus_fdata;
  logic       commit;
  logic       accept;
  logic       busy_next;
  logic       bus_wr;
  logic       fw_en;
  logic [6:0] fw_addr;
  logic [7:0] fw_data;
  logic       low_wr;
  logic       size_unused;

  assign hrdata      = s_reg.hrdata;
  assign hreadyout   = s_reg.hreadyout;
  assign hresp       = s_reg.hresp;
  assign size_unused = ^hsize;

  // special registers answer in place of the array
  function automatic logic [7:0] file_read(input logic [6:0] a, input ifd_pkg::ifd_state_t s,
                                           input logic [7:0] mem_val);
    case (a)
      ifd_pkg::FILE_PC_LOW: file_read = s.pc[7:0];
      ifd_pkg::FILE_STATUS: file_read = s.status;
      ifd_pkg::FILE_LATCH:  file_read = {3'h0, s.latch};
      default:              file_read = mem_val;
    endcase
  endfunction

  assign core_fdata = file_read(dec.faddr, s_reg, file_mem[dec.faddr]);
  assign bus_fdata  = file_read(s_reg.faddr, s_reg, file_mem[s_reg.faddr]);

  ifd_field_decode ifd_field_decode_inst (
    .instr    (s_reg.instr),
    .wreg     (s_reg.w),
    .fdata    (core_fdata),
    .carry_in (s_reg.status[ifd_pkg::ST_C]),
    .dec      (dec)
  );

  always_comb
  begin
    s_next    = s_reg;
    mem_we    = 1'b0;
    mem_waddr = '0;
    mem_wdata = '0;
    fw_en     = 1'b0;
    fw_addr   = dec.faddr;
    fw_data   = dec.result;
    commit    = s_reg.phase == ifd_pkg::PH_EXEC && s_reg.q == ifd_pkg::Q_LAST;
    bus_wr    = s_reg.dp_valid && s_reg.dp_write && s_reg.hreadyout;
    accept    = hsel && htrans[1] && hready;

    // quarter sequencer: four clocks per instruction cycle
    if (s_reg.phase != ifd_pkg::PH_IDLE)
    begin
      s_next.q = s_reg.q + 2'h1;
      if (s_reg.q == ifd_pkg::Q_LAST)
      begin
        s_next.cycles = s_reg.cycles + 32'h1;
        if (s_reg.phase == ifd_pkg::PH_NOP)
          s_next.phase = ifd_pkg::PH_IDLE;
      end
    end

    // bus writes only complete while the core is idle
    if (bus_wr)
    begin
      case (s_reg.dp_addr)
        ifd_pkg::ADDR_INSTR:
        begin
          s_next.instr = hwdata[13:0];
          s_next.phase = ifd_pkg::PH_EXEC;
          s_next.q     = 2'h0;
        end
        ifd_pkg::ADDR_WREG:  s_next.w = hwdata[7:0];
        ifd_pkg::ADDR_PC:    s_next.pc = hwdata[12:0];
        ifd_pkg::ADDR_FADDR: s_next.faddr = hwdata[6:0];
        ifd_pkg::ADDR_FDATA:
        begin
          fw_en   = 1'b1;
          fw_addr = s_reg.faddr;
          fw_data = hwdata[7:0];
        end
        default: ;
      endcase
    end
    if (commit)
      fw_en = dec.wr_file;

    // data-register write with special destinations
    low_wr = fw_en && fw_addr == ifd_pkg::FILE_PC_LOW;
    if (fw_en)
    begin
      case (fw_addr)
        ifd_pkg::FILE_PC_LOW: s_next.pc = {s_reg.latch, fw_data};
        ifd_pkg::FILE_STATUS: s_next.status = fw_data;
        ifd_pkg::FILE_LATCH:  s_next.latch = fw_data[4:0];
        default:
        begin
          mem_we    = 1'b1;
          mem_waddr = fw_addr;
          mem_wdata = fw_data;
        end
      endcase
    end

    if (commit)
    begin
      // flags land after the stored value
      s_next.status[2:0] = (s_next.status[2:0] & ~dec.fmask) | (dec.fval & dec.fmask);
      if (dec.wr_w)
        s_next.w = dec.result;
      if (dec.jump)
        s_next.pc = {s_reg.latch[4:3], dec.k11};
      else if (!low_wr)
        s_next.pc = s_reg.pc + 13'h0001;
      if (dec.skip || dec.jump || dec.ret || low_wr)
        s_next.phase = ifd_pkg::PH_NOP;
      else
        s_next.phase = ifd_pkg::PH_IDLE;
    end

    // AHB-Lite slave; writes stall while an instruction runs
    busy_next    = s_next.phase != ifd_pkg::PH_IDLE;
    s_next.hresp = ifd_pkg::HRESP_OKAY;
    if (s_reg.dp_valid && !s_reg.hreadyout)
      s_next.hreadyout = !busy_next;
    else
    begin
      s_next.dp_valid  = accept;
      s_next.dp_write  = hwrite;
      s_next.dp_addr   = haddr[7:0];
      s_next.hreadyout = !(accept && hwrite && busy_next);
      if (accept && !hwrite)
      begin
        case (haddr[7:0])
          ifd_pkg::ADDR_INSTR: s_next.hrdata = {18'h0, s_reg.instr};
          ifd_pkg::ADDR_WREG:  s_next.hrdata = {24'h0, s_reg.w};
          ifd_pkg::ADDR_STAT:  s_next.hrdata = {19'h0, dec.cls, s_reg.q,
                                                s_reg.phase != ifd_pkg::PH_IDLE, s_reg.status};
          ifd_pkg::ADDR_PC:    s_next.hrdata = {19'h0, s_reg.pc};
          ifd_pkg::ADDR_FADDR: s_next.hrdata = {25'h0, s_reg.faddr};
          ifd_pkg::ADDR_FDATA: s_next.hrdata = {24'h0, bus_fdata};
          ifd_pkg::ADDR_CYC:   s_next.hrdata = s_reg.cycles;
          default:             s_next.hrdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_reg           <= '0;
      s_reg.phase     <= ifd_pkg::PH_IDLE;
      s_reg.instr     <= ifd_pkg::INSTR_RST;
      s_reg.w         <= ifd_pkg::W_RST;
      s_reg.status    <= ifd_pkg::STATUS_RST;
      s_reg.pc        <= ifd_pkg::PC_RST;
      s_reg.latch     <= ifd_pkg::LATCH_RST;
      s_reg.hreadyout <= 1'b1;
      s_reg.hresp     <= ifd_pkg::HRESP_OKAY;
    end
    else if (ce)
      s_reg <= s_next;
  end

  always_ff @(posedge hclk)
  begin
    if (ce && mem_we)
      file_mem[mem_waddr] <= mem_wdata;
  end

  chk_cycle_four_q: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    (s_reg.phase == ifd_pkg::PH_IDLE && s_next.phase == ifd_pkg::PH_EXEC)
    |=> (s_reg.phase == ifd_pkg::PH_EXEC)[*4] ##1 s_reg.phase != ifd_pkg::PH_EXEC)
    else $error("instruction cycle is not four clocks");

  chk_nop_second_cycle: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    (commit && (dec.skip || dec.jump))
    |=> (s_reg.phase == ifd_pkg::PH_NOP)[*4] ##1 s_reg.phase == ifd_pkg::PH_IDLE)
    else $error("taken branch did not add one no-op cycle");

  chk_dest_accum: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    (commit && dec.cls == ifd_pkg::IFD_BYTE && !s_reg.instr[7] && s_reg.instr[11:8] != 4'h0)
    |=> s_reg.w == $past(dec.result) && $stable(s_reg.status[7:3]))
    else $error("d=0 result missing from accumulator");

  chk_status_flags: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    (commit && dec.wr_file && dec.faddr == ifd_pkg::FILE_STATUS)
    |=> ((s_reg.status[2:0] ^ $past(dec.fval)) & $past(dec.fmask)) == 3'h0)
    else $error("flags did not override status write");

  chk_clear_status: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    (commit && s_reg.instr[13:7] == 7'h03 && dec.faddr == ifd_pkg::FILE_STATUS)
    |=> s_reg.status == 8'h04)
    else $error("cleared status does not read 0x04");

  chk_lowbyte_write_latch: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    (commit && dec.wr_file && dec.faddr == ifd_pkg::FILE_PC_LOW)
    |=> s_reg.pc == {$past(s_reg.latch), $past(dec.result)} && s_reg.phase == ifd_pkg::PH_NOP)
    else $error("low byte write did not load high byte from latch");

  chk_lowbyte_read_value: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    (commit && dec.faddr == ifd_pkg::FILE_PC_LOW && !dec.wr_file && !dec.jump)
    |-> core_fdata == s_reg.pc[7:0] ##1 s_reg.pc == $past(s_reg.pc) + 13'h0001)
    else $error("low byte read disturbed the counter");

  chk_lowbyte_rmw_incr: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    (commit && s_reg.instr[13:7] == 7'h15 && dec.faddr == ifd_pkg::FILE_PC_LOW)
    |=> s_reg.pc[7:0] == $past(s_reg.pc[7:0]) + 8'h01 && s_reg.pc[12:8] == $past(s_reg.latch))
    else $error("increment of low byte used wrong operand");

  chk_bit_only_one: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    (commit && dec.cls == ifd_pkg::IFD_BIT && !s_reg.instr[11])
    |-> ((dec.result ^ core_fdata) & ~(8'h01 << s_reg.instr[9:7])) == 8'h00
        && dec.result[s_reg.instr[9:7]] == s_reg.instr[10])
    else $error("bit operation touched other bits");

  chk_quarter_step: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    s_reg.phase != ifd_pkg::PH_IDLE |=> s_reg.q == $past(s_reg.q) + 2'h1)
    else $error("quarter count did not advance by one");

  chk_class_fields: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    dec.faddr == s_reg.instr[6:0]
    && dec.cls == (s_reg.instr[13] ? ifd_pkg::IFD_LITCTL : s_reg.instr[12] ? ifd_pkg::IFD_BIT : ifd_pkg::IFD_BYTE))
    else $error("class or file address field decoded wrongly");

  chk_nop_no_effect: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    s_reg.phase == ifd_pkg::PH_NOP
    |=> $stable(s_reg.w) && $stable(s_reg.status) && $stable(s_reg.pc) && $stable(s_reg.latch))
    else $error("no-op cycle changed core state");

  chk_dest_file: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    (commit && dec.cls == ifd_pkg::IFD_BYTE && s_reg.instr[7] && s_reg.instr[11:8] != 4'h0
     && dec.faddr > ifd_pkg::FILE_LATCH)
    |=> file_mem[$past(dec.faddr)] == $past(dec.result) && $stable(s_reg.w))
    else $error("d=1 result missing from data register");

  chk_pc_advance: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    (commit && !dec.jump && !low_wr) |=> s_reg.pc == $past(s_reg.pc) + 13'h0001)
    else $error("counter did not step past a plain instruction");

  chk_literal_sub: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    (commit && s_reg.instr[13:9] == 5'h1E)
    |=> s_reg.w == $past(s_reg.instr[7:0]) - $past(s_reg.w))
    else $error("subtract-from-literal result wrong");

  chk_stall_bounded: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    (s_reg.dp_valid && !s_reg.hreadyout) |-> ##[1:9] s_reg.hreadyout)
    else $error("write stall exceeded two instruction cycles");

endmodule

// File: ifd_core_top_tb.sv
/*
  Self-checking bench for the instruction field decoder core: it loads
  instructions over AHB-Lite and checks the results through the registers.
  Assumes the slave is alone on the bus, so hready is fed from hreadyout.
*/
`timescale 1ns/1ps
module instr_field_decode_pcl_status_tb_top;
  logic        hclk    = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel    = 1'b0;
  logic        hwrite  = 1'b0;
  logic [1:0]  htrans  = 2'h0;
  logic [31:0] haddr   = 32'h0;
  logic [31:0] hwdata  = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] d;
  logic [31:0] c0;
  int          err_total = 0;
  int          tests_run = 0;
  int          clk_n     = 0;
  int          n1;
  int          n2;

  always #10 hclk = ~hclk;
  always @(posedge hclk) clk_n++;

  ifd_core_top ifd_core_top_inst (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .ce        (1'b1),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (3'h2),
    .hready    (hreadyout),
    .hwdata    (hwdata),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp)
  );

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // one single transfer: address phase, then data phase, each held until hready
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
    logic ok;
    int   n;
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= ifd_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    for (int ph = 0; ph < 2; ph++)
    begin
      ok = 1'b0;
      n  = 0;
      while (!ok)
      begin
        @(negedge hclk);
        ok = (hreadyout === 1'b1);
        rd = hrdata;
        @(posedge hclk);
        n++;
        if (n > 200)
        begin
          chk(32'h0, 32'h1, "bus wait ran out");
          close_out();
        end
      end
      if (ph == 0)
      begin
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
      end
    end
    chk({31'h0, hresp}, {31'h0, ifd_pkg::HRESP_OKAY}, "response");
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] dummy;
    bus(a, 1'b1, v, dummy);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    bus(a, 1'b0, 32'h0, v);
  endtask

  task automatic idle();
    logic [31:0] s;
    for (int n = 0; n < 50; n++)
    begin
      rd(ifd_pkg::ADDR_STAT, s);
      if (s[8] === 1'b0)
        return;
    end
    chk(32'h0, 32'h1, "core never went idle");
    close_out();
  endtask

  task automatic ex(input logic [13:0] i);
    wr(ifd_pkg::ADDR_INSTR, {18'h0, i});
    idle();
  endtask

  task automatic setf(input logic [6:0] a, input logic [7:0] v);
    wr(ifd_pkg::ADDR_FADDR, {25'h0, a});
    wr(ifd_pkg::ADDR_FDATA, {24'h0, v});
  endtask

  task automatic getf(input logic [6:0] a, output logic [31:0] v);
    wr(ifd_pkg::ADDR_FADDR, {25'h0, a});
    rd(ifd_pkg::ADDR_FDATA, v);
  endtask

  // instruction-cycle count added by one instruction
  task automatic cyc_of(input logic [13:0] i, input int exp);
    logic [31:0] a;
    logic [31:0] b;
    rd(ifd_pkg::ADDR_CYC, a);
    ex(i);
    rd(ifd_pkg::ADDR_CYC, b);
    chk(b - a, 32'(exp), "cycle count");
  endtask

  // clocks a whole write takes, address phase to done, when issued behind the given instruction
  task automatic stall(input logic [13:0] i, output int n);
    int t;
    wr(ifd_pkg::ADDR_INSTR, {18'h0, i});
    t = clk_n;
    wr(ifd_pkg::ADDR_INSTR, 32'h0000_3000);
    n = clk_n - t;
    idle();
  endtask

  task automatic t_reset();
    rd(ifd_pkg::ADDR_WREG, d);
    chk(d, 32'h0, "accumulator after reset");
    rd(ifd_pkg::ADDR_STAT, d);
    chk(d, 32'h0, "status after reset");
    rd(ifd_pkg::ADDR_PC, d);
    chk(d, 32'h0, "counter after reset");
    rd(ifd_pkg::ADDR_CYC, d);
    chk(d, 32'h0, "cycles after reset");
    wr(8'h1C, 32'hFFFF_FFFF);
    rd(8'h1C, d);
    chk(d, 32'h0, "unmapped place");
  endtask

  task automatic t_fields();
    wr(ifd_pkg::ADDR_FADDR, 32'hFFFF_FFFF);
    rd(ifd_pkg::ADDR_FADDR, d);
    chk(d, 32'h0000_007F, "file pointer width");
    wr(ifd_pkg::ADDR_INSTR, 32'hFFFF_3022);
    idle();
    rd(ifd_pkg::ADDR_INSTR, d);
    chk(d, 32'h0000_3022, "instruction word width");
    ex(14'h305A);
    ex(14'h00FF);
    ex(14'h0080);
    getf(7'h00, d);
    chk(d, 32'h0000_005A, "lowest file address");
    rd(ifd_pkg::ADDR_STAT, d);
    chk({30'h0, d[12:11]}, 32'h0, "byte class");
    ex(14'h0A7F);
    rd(ifd_pkg::ADDR_WREG, d);
    chk(d, 32'h0000_005B, "result to accumulator");
    getf(7'h7F, d);
    chk(d, 32'h0000_005A, "file kept when d is 0");
    ex(14'h0AFF);
    getf(7'h7F, d);
    chk(d, 32'h0000_005B, "result to highest file");
  endtask

  task automatic t_bits();
    for (int b = 0; b < 8; b++)
    begin
      setf(7'h20, 8'h00);
      ex({4'h5, 3'(b), 7'h20});
      getf(7'h20, d);
      chk(d, 32'h1 << b, "bit set");
      setf(7'h20, 8'hFF);
      ex({4'h4, 3'(b), 7'h20});
      getf(7'h20, d);
      chk(d, 32'hFF & ~(32'h1 << b), "bit clear");
    end
    rd(ifd_pkg::ADDR_STAT, d);
    chk({30'h0, d[12:11]}, 32'h1, "bit class");
  endtask

  task automatic t_dontcare();
    ex(14'h3311);
    rd(ifd_pkg::ADDR_WREG, d);
    chk(d, 32'h0000_0011, "load with loose bits set");
    rd(ifd_pkg::ADDR_STAT, d);
    chk({30'h0, d[12:11]}, 32'h2, "literal class");
    ex(14'h3E05);
    ex(14'h3F05);
    ex(14'h0060);
    rd(ifd_pkg::ADDR_WREG, d);
    chk(d, 32'h0000_001B, "add both forms, idle op");
    ex(14'h3C20);
    rd(ifd_pkg::ADDR_WREG, d);
    chk(d, 32'h0000_0005, "subtract from literal");
    ex(14'h3D20);
    rd(ifd_pkg::ADDR_WREG, d);
    chk(d, 32'h0000_001B, "subtract, loose bit set");
  endtask

  task automatic t_timing();
    stall(14'h3000, n1);
    stall(14'h2800, n2);
    chk(32'(n2 - n1), 32'(ifd_pkg::Q_PER_CYCLE), "extra clocks of a branch");
    cyc_of(14'h3000, 1);
    cyc_of(14'h2800, 2);
    setf(7'h20, 8'h01);
    cyc_of(14'h1C20, 2);
    cyc_of(14'h1820, 1);
  endtask

  task automatic t_status();
    ex(14'h30FF);
    ex(14'h0083);
    rd(ifd_pkg::ADDR_STAT, d);
    chk({24'h0, d[7:0]}, 32'h0000_00FF, "plain status write");
    ex(14'h0883);
    rd(ifd_pkg::ADDR_STAT, d);
    chk({24'h0, d[7:0]}, 32'h0000_00FB, "zero flag overrides");
    ex(14'h0183);
    rd(ifd_pkg::ADDR_STAT, d);
    chk({24'h0, d[7:0]}, 32'h0000_0004, "status wipe");
  endtask

  task automatic t_counter();
    ex(14'h3003);
    ex(14'h008A);
    ex(14'h2923);
    rd(ifd_pkg::ADDR_PC, d);
    chk(d, 32'h0000_0123, "jump target");
    ex(14'h0802);
    rd(ifd_pkg::ADDR_WREG, d);
    chk(d, 32'h0000_0023, "low byte read");
    rd(ifd_pkg::ADDR_PC, d);
    chk(d, 32'h0000_0124, "counter after read");
    ex(14'h3040);
    cyc_of(14'h0082, 2);
    rd(ifd_pkg::ADDR_PC, d);
    chk(d, 32'h0000_0340, "low byte write");
    ex(14'h3005);
    ex(14'h008A);
    ex(14'h0782);
    rd(ifd_pkg::ADDR_PC, d);
    chk(d, 32'h0000_0547, "low byte modify");
    ex(14'h0A82);
    rd(ifd_pkg::ADDR_PC, d);
    chk(d, 32'h0000_0548, "low byte increment");
  endtask

  initial
  begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_fields();
    t_bits();
    t_dontcare();
    t_timing();
    t_status();
    t_counter();
    close_out();
  end
endmodule
